// ===== core/event_ack.sv
`timescale 1ns/10ps
// per-source pending and acknowledge tracking
module event_ack #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  input  wire logic             clk_en,
  // status and control
  input  wire logic [WIDTH-1:0] status,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic [WIDTH-1:0] ack_set,
  // results
  output logic [WIDTH-1:0]      pending,
  output logic [WIDTH-1:0]      ack
);
  // elaboration check on the width
  if (WIDTH < 1) begin : g_width_check
    $error("event_ack width must be at least one");
  end

  logic [WIDTH-1:0] prev_q, prev_d, pend_q, pend_d, ack_q, ack_d;

  // rising edges latch pending, ack set and auto-cleared
  always_comb begin
    prev_d = status;
    pend_d = (pend_q | (status & ~prev_q)) & status & ~ack_q;
    ack_d  = (ack_q | (ack_set & pend_q)) & status;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= '0; pend_q <= '0; ack_q <= '0;
    end else if (clk_en) begin
      prev_q <= prev_d; pend_q <= pend_d; ack_q <= ack_d;
    end
  end

  assign pending = pend_q & ~mask & ~ack_q;
  assign ack     = ack_q;
endmodule

// ===== core/pmic_event_and_charger_control.sv
`timescale 1ns/10ps
// What this block does
// - ldo1 flag high when out of regulation; low when regulating or disabled
// - main converter flag high exactly when out of regulation
// - core flag high when out of regulation or off in low-power mode
// - rising edge of a rail status bit pulls interrupt low unless masked
// - charge mask bits block charger events; reset all ones
// - rail mask bits block rail events; reset all ones
// - charge acknowledge removes event; pin releases when nothing else pending
// - rail acknowledge removes event; pin releases only when all clear
// - acknowledge bits auto-clear when matching status goes away
// - inhibit clear: valid source and supply ok forces on mode, no wait
// - inhibit set: source leaves wait enabled, no automatic turn-on
// - host pulses charger reset; device clears timers and restarts charging
// - timer enable off: taper bit shows comparator; on: shows taper timer
// - current field selects 100, 75, 50 or 25 percent of maximum
// - usb limit 100 mA or 500 mA; ignored when usb not allowed
// - no usb charging unless usb allowed bit is set
// - charge enable gates charging; ac preferred when both sources valid
// - bus address is 100100 plus strap pin
// - reads of unmapped addresses return all ones
module pmic_event_and_charger_control (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       bus_address_low_strap,
  // rail monitors
  input  wire logic       ldo1_out_of_reg,
  input  wire logic       ldo1_enabled,
  input  wire logic       main_out_of_reg,
  input  wire logic       core_out_of_reg,
  input  wire logic       low_power_mode,
  input  wire logic       core_off_in_low_power,
  input  wire logic [4:0] rail_status_upper,
  // charger monitors
  input  wire logic [7:0] charge_status_reg,
  input  wire logic       taper_comparator,
  input  wire logic       taper_timer_done,
  input  wire logic       ac_valid,
  input  wire logic       usb_valid,
  input  wire logic       supply_above_lockout,
  // internal acknowledge sources
  input  wire logic [7:0] charge_ack_set,
  input  wire logic [7:0] rail_ack_set,
  // interrupt pin
  output logic            int_n,
  // power mode control
  output logic            force_on_mode,
  output logic            wait_mode_enable,
  // charger control
  output logic            charger_restart,
  output logic            fast_timer_enable,
  output logic [2:0]      charge_current_quarters,
  output logic            usb_limit_500,
  output logic            charge_from_ac,
  output logic            charge_from_usb
);
  // bus side
  logic [7:0] reg_addr, wr_data, rd_data;
  logic       wr_stb, slave_oe;

  serial_slave u_slave (
    .ref_clk               (ref_clk),
    .arst_n                (arst_n),
    .clk_en                (clk_en),
    .scl_in                (scl_in),
    .sda_in                (sda_in),
    .sda_oe                (slave_oe),
    .bus_address_low_strap (bus_address_low_strap),
    .reg_addr              (reg_addr),
    .wr_data               (wr_data),
    .wr_stb                (wr_stb),
    .rd_data               (rd_data)
  );

  // software registers
  logic [7:0] cmask_q, cmask_d, rmask_q, rmask_d, setup_q, setup_d;

  always_comb begin
    cmask_d = cmask_q;
    rmask_d = rmask_q;
    setup_d = setup_q;
    if (wr_stb) begin
      case (reg_addr)
        pmic_event_pkg::ADDR_CHARGE_MASK:   cmask_d = wr_data;
        pmic_event_pkg::ADDR_RAIL_MASK:     rmask_d = wr_data;
        pmic_event_pkg::ADDR_CHARGER_SETUP: setup_d = wr_data;
        default: ; // acknowledge and status registers ignore writes
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmask_q <= pmic_event_pkg::MASK_RESET;
      rmask_q <= pmic_event_pkg::MASK_RESET;
      setup_q <= pmic_event_pkg::SETUP_RESET;
    end else if (clk_en) begin
      cmask_q <= cmask_d;
      rmask_q <= rmask_d;
      setup_q <= setup_d;
    end
  end

  // status composition
  logic [7:0] rail_status, charge_status;

  always_comb begin
    rail_status = {rail_status_upper, 3'h0};
    rail_status[pmic_event_pkg::RAIL_LDO1] = ldo1_enabled & ldo1_out_of_reg;
    rail_status[pmic_event_pkg::RAIL_MAIN] = main_out_of_reg;
    rail_status[pmic_event_pkg::RAIL_CORE] = core_out_of_reg
                                           | (low_power_mode & core_off_in_low_power);
    charge_status = charge_status_reg;
    charge_status[pmic_event_pkg::CHG_TAPER] =
      setup_q[pmic_event_pkg::SETUP_TIMER_EN] ? taper_timer_done : taper_comparator;
  end

  // pending and acknowledge per source
  logic [7:0] cpend, rpend, cack, rack;

  event_ack #(.WIDTH(8)) u_charge_events (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .status  (charge_status),
    .mask    (cmask_q),
    .ack_set (charge_ack_set),
    .pending (cpend),
    .ack     (cack)
  );

  event_ack #(.WIDTH(8)) u_rail_events (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .clk_en  (clk_en),
    .status  (rail_status),
    .mask    (rmask_q),
    .ack_set (rail_ack_set),
    .pending (rpend),
    .ack     (rack)
  );

  // read mux
  always_comb begin
    case (reg_addr)
      pmic_event_pkg::ADDR_CHARGE_STATUS: rd_data = charge_status;
      pmic_event_pkg::ADDR_RAIL_STATUS:   rd_data = rail_status;
      pmic_event_pkg::ADDR_CHARGE_MASK:   rd_data = cmask_q;
      pmic_event_pkg::ADDR_RAIL_MASK:     rd_data = rmask_q;
      pmic_event_pkg::ADDR_CHARGE_ACK:    rd_data = cack;
      pmic_event_pkg::ADDR_RAIL_ACK:      rd_data = rack;
      pmic_event_pkg::ADDR_CHARGER_SETUP: rd_data = setup_q;
      default:                            rd_data = pmic_event_pkg::UNMAPPED_READ;
    endcase
  end

  function automatic logic [2:0] current_quarters(input logic [1:0] sel);
    case (sel)
      2'h3:    current_quarters = pmic_event_pkg::CUR_QUARTERS_FULL;
      2'h2:    current_quarters = pmic_event_pkg::CUR_QUARTERS_75;
      2'h1:    current_quarters = pmic_event_pkg::CUR_QUARTERS_50;
      default: current_quarters = pmic_event_pkg::CUR_QUARTERS_25;
    endcase
  endfunction

  // output next values
  logic       int_n_d, force_on_d, wait_en_d, restart_d, timer_d, usb500_d, ac_d, usb_d;
  logic       reset_bit_q;
  logic [2:0] cur_d;
  logic       chg_en, usb_ok, src_ok;

  always_comb begin
    chg_en    = setup_q[pmic_event_pkg::SETUP_CHG_EN];
    usb_ok    = setup_q[pmic_event_pkg::SETUP_USB_ALLOWED];
    src_ok    = (ac_valid | usb_valid) & supply_above_lockout;
    int_n_d   = ~(|cpend | |rpend);
    force_on_d = ~setup_q[pmic_event_pkg::SETUP_AUTO_INHIBIT] & src_ok;
    wait_en_d  = ~force_on_d;
    // reset pulse on the high-to-low write of the reset bit
    restart_d = reset_bit_q & ~setup_q[pmic_event_pkg::SETUP_CHG_RESET];
    timer_d   = setup_q[pmic_event_pkg::SETUP_TIMER_EN];
    cur_d     = current_quarters(setup_q[pmic_event_pkg::SETUP_CUR_MSB:
                                         pmic_event_pkg::SETUP_CUR_LSB]);
    usb500_d  = usb_ok & setup_q[pmic_event_pkg::SETUP_USB_500];
    ac_d      = chg_en & ac_valid;
    usb_d     = chg_en & usb_ok & usb_valid & ~ac_valid;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_n <= 1'b1; force_on_mode <= 1'b0; wait_mode_enable <= 1'b1;
      charger_restart <= 1'b0; fast_timer_enable <= 1'b0;
      charge_current_quarters <= pmic_event_pkg::CUR_QUARTERS_FULL;
      usb_limit_500 <= 1'b0; charge_from_ac <= 1'b0; charge_from_usb <= 1'b0;
      reset_bit_q <= 1'b0; sda_oe <= 1'b0;
    end else if (clk_en) begin
      int_n <= int_n_d; force_on_mode <= force_on_d; wait_mode_enable <= wait_en_d;
      charger_restart <= restart_d; fast_timer_enable <= timer_d;
      charge_current_quarters <= cur_d;
      usb_limit_500 <= usb500_d; charge_from_ac <= ac_d; charge_from_usb <= usb_d;
      reset_bit_q <= setup_q[pmic_event_pkg::SETUP_CHG_RESET]; sda_oe <= slave_oe;
    end
  end

  // open-drain data line only ever pulls low
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) sda_out <= 1'b0;
    else sda_out <= 1'b0;
  end
endmodule

// ===== core/pmic_event_pkg.sv
package pmic_event_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CHARGE_STATUS = 8'h01;
  localparam logic [7:0] ADDR_RAIL_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_CHARGE_MASK   = 8'h03;
  localparam logic [7:0] ADDR_RAIL_MASK     = 8'h04;
  localparam logic [7:0] ADDR_CHARGE_ACK    = 8'h05;
  localparam logic [7:0] ADDR_RAIL_ACK      = 8'h06;
  localparam logic [7:0] ADDR_CHARGER_SETUP = 8'h07;
  // reset values
  localparam logic [7:0] MASK_RESET         = 8'hff;
  localparam logic [7:0] ACK_RESET          = 8'h00;
  localparam logic [7:0] SETUP_RESET        = 8'h1b;
  localparam logic [7:0] UNMAPPED_READ      = 8'hff;
  // charger_setup field positions
  localparam int SETUP_AUTO_INHIBIT = 7;
  localparam int SETUP_CHG_RESET    = 6;
  localparam int SETUP_TIMER_EN     = 5;
  localparam int SETUP_CUR_MSB      = 4;
  localparam int SETUP_CUR_LSB      = 3;
  localparam int SETUP_USB_500      = 2;
  localparam int SETUP_USB_ALLOWED  = 1;
  localparam int SETUP_CHG_EN       = 0;
  // rail status bit positions and charge status taper bit position
  localparam int RAIL_LDO1 = 2;
  localparam int RAIL_MAIN = 1;
  localparam int RAIL_CORE = 0;
  localparam int CHG_TAPER = 3;
  // bus address upper six bits
  localparam logic [5:0] BUS_ADDR_HIGH = 6'h24;
  // charge current in quarters of the resistor maximum
  localparam logic [2:0] CUR_QUARTERS_FULL = 3'h4;
  localparam logic [2:0] CUR_QUARTERS_75   = 3'h3;
  localparam logic [2:0] CUR_QUARTERS_50   = 3'h2;
  localparam logic [2:0] CUR_QUARTERS_25   = 3'h1;
endpackage

// ===== core/serial_slave.sv
`timescale 1ns/10ps
// byte-oriented two-wire slave, lines sampled on ref_clk
module serial_slave (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  // bus lines
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe,
  // address strap
  input  wire logic       bus_address_low_strap,
  // register side
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  output logic            wr_stb,
  input  wire logic [7:0] rd_data
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_DEV = 6'b000010, S_ACK = 6'b000100,
    S_WR   = 6'b001000, S_RD  = 6'b010000, S_MACK = 6'b100000
  } st_e;

  st_e        st_q, st_d;
  logic       scl_q, sda_q, sda_oe_q, sda_oe_d, rw_q, rw_d, wr_stb_q, wr_stb_d;
  logic [7:0] sh_q, sh_d, addr_q, addr_d, wdat_q, wdat_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] phase_q, phase_d; // 0 device byte, 1 register byte, 2 data
  logic       rise, fall, start, stop;

  assign rise  = scl_in & ~scl_q;
  assign fall  = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop  = scl_in & scl_q & ~sda_q & sda_in;

  // next-state logic of the byte engine
  always_comb begin
    st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; addr_d = addr_q; wdat_d = wdat_q;
    rw_d = rw_q; phase_d = phase_q; sda_oe_d = sda_oe_q; wr_stb_d = 1'b0;
    if (start) begin
      st_d = S_DEV; cnt_d = 4'h0; phase_d = 2'h0; sda_oe_d = 1'b0;
    end else if (stop) begin
      st_d = S_IDLE; sda_oe_d = 1'b0;
    end else begin
      case (st_q)
        S_IDLE: sda_oe_d = 1'b0;
        S_DEV, S_WR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_in};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (phase_q == 2'h0) begin
              // own address: 100100 plus strap
              if (sh_q[7:1] == {pmic_event_pkg::BUS_ADDR_HIGH, bus_address_low_strap}) begin
                rw_d = sh_q[0]; sda_oe_d = 1'b1; st_d = S_ACK;
              end else st_d = S_IDLE;
            end else begin
              sda_oe_d = 1'b1; st_d = S_ACK;
              if (phase_q == 2'h1) addr_d = sh_q;
              else begin
                wdat_d = sh_q; wr_stb_d = 1'b1;
              end
            end
          end
        end
        S_ACK: if (fall) begin
          if (phase_q == 2'h0 && rw_q) begin
            sh_d = rd_data; st_d = S_RD; sda_oe_d = ~rd_data[7];
            phase_d = 2'h2;
          end else begin
            sda_oe_d = 1'b0; st_d = S_WR;
            if (phase_q == 2'h2) addr_d = addr_q + 8'h01;
            if (phase_q != 2'h2) phase_d = phase_q + 2'h1;
          end
        end
        S_RD: if (fall) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            sda_oe_d = 1'b0; st_d = S_MACK; cnt_d = 4'h0;
          end else begin
            sh_d = {sh_q[6:0], 1'b1}; sda_oe_d = ~sh_q[6];
          end
        end
        S_MACK: if (rise) begin
          if (sda_in) st_d = S_IDLE; // master nack ends the read
          else begin
            addr_d = addr_q + 8'h01; st_d = S_ACK; phase_d = 2'h0;
          end
        end
        default: st_d = S_IDLE;
      endcase
    end
  end

  // register the byte engine
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= S_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; sh_q <= 8'h00; cnt_q <= 4'h0;
      addr_q <= 8'h00; wdat_q <= 8'h00; rw_q <= 1'b0; phase_q <= 2'h0;
      sda_oe_q <= 1'b0; wr_stb_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d; scl_q <= scl_in; sda_q <= sda_in; sh_q <= sh_d; cnt_q <= cnt_d;
      addr_q <= addr_d; wdat_q <= wdat_d; rw_q <= rw_d; phase_q <= phase_d;
      sda_oe_q <= sda_oe_d; wr_stb_q <= wr_stb_d;
    end
  end

  assign sda_oe   = sda_oe_q;
  assign reg_addr = addr_q;
  assign wr_data  = wdat_q;
  assign wr_stb   = wr_stb_q;
endmodule

// ===== verif/pmic_event_and_charger_control_tb.sv
`timescale 1ns/10ps
// self-checking bench for the event and charger block
module pmic_event_and_charger_control_tb;
  // clock, reset, bus
  logic        ref_clk = 1'b0, arst_n = 1'b0, bus_address_low_strap = 1'b0, clk_en = 1'b1;
  logic        scl_in, sda_in, sda_out, sda_oe;
  // monitor inputs
  logic        ldo1_out_of_reg = 1'b0, ldo1_enabled = 1'b0, main_out_of_reg = 1'b0;
  logic        core_out_of_reg = 1'b0, low_power_mode = 1'b0, core_off_in_low_power = 1'b0;
  logic        taper_comparator = 1'b0, taper_timer_done = 1'b0, ac_valid = 1'b0;
  logic        usb_valid = 1'b0, supply_above_lockout = 1'b0;
  logic [4:0]  rail_status_upper = 5'h00;
  logic [7:0]  charge_status_reg = 8'h00, charge_ack_set = 8'h00, rail_ack_set = 8'h00;
  // outputs
  logic        int_n, force_on_mode, wait_mode_enable, charger_restart, fast_timer_enable;
  logic        usb_limit_500, charge_from_ac, charge_from_usb;
  logic [2:0]  charge_current_quarters;
  // bench state
  int          err_count = 0, n_compared = 0, restarts = 0;
  logic [31:0] seed = 32'h0000005b;
  logic [7:0]  rd, s, v;
  logic [6:0]  dev;
  logic        ok;
  always #20 ref_clk = ~ref_clk;
  // count restart pulses
  always @(posedge ref_clk) if (charger_restart === 1'b1) restarts <= restarts + 1;
  pmic_event_and_charger_control dut (
    .ref_clk, .arst_n, .clk_en, .scl_in, .sda_in, .sda_out, .sda_oe,
    .bus_address_low_strap, .ldo1_out_of_reg, .ldo1_enabled, .main_out_of_reg,
    .core_out_of_reg, .low_power_mode, .core_off_in_low_power, .rail_status_upper,
    .charge_status_reg, .taper_comparator, .taper_timer_done, .ac_valid, .usb_valid,
    .supply_above_lockout, .charge_ack_set, .rail_ack_set, .int_n, .force_on_mode,
    .wait_mode_enable, .charger_restart, .fast_timer_enable, .charge_current_quarters,
    .usb_limit_500, .charge_from_ac, .charge_from_usb
  );
  serial_master m (.ref_clk, .sda_oe, .scl_in, .sda_in);
  // xorshift source
  task automatic rnd(output logic [7:0] r);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    r = seed[7:0];
  endtask
  // expected rail status from monitor inputs
  function automatic logic [7:0] exp_rail();
    return {rail_status_upper, ldo1_out_of_reg & ldo1_enabled, main_out_of_reg,
            core_out_of_reg | (low_power_mode & core_off_in_low_power)};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("FAIL %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    m.rd(dev, a, rd);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    m.wr(dev, a, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  // bounded wait on the interrupt pin
  task automatic wait_int(input logic e);
    for (int i = 0; i < 10 && int_n !== e; i++) @(posedge ref_clk);
    chk("int_n", {7'h00, e}, {7'h00, int_n});
    if (int_n !== e) report_and_stop();
  endtask
  task automatic pulse_ack(input logic [7:0] c, input logic [7:0] r);
    @(posedge ref_clk);
    charge_ack_set <= c;
    rail_ack_set <= r;
    @(posedge ref_clk);
    charge_ack_set <= 8'h00;
    rail_ack_set <= 8'h00;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic chk_setup(input logic [7:0] c);
    chk("quarters", {5'h00, 3'({1'b0, c[4:3]} + 3'h1)}, {5'h00, charge_current_quarters});
    chk("timer", {7'h00, c[5]}, {7'h00, fast_timer_enable});
    chk("usb500", {7'h00, c[2] & c[1]}, {7'h00, usb_limit_500});
    chk("ac", {7'h00, c[0] & ac_valid}, {7'h00, charge_from_ac});
    chk("usb", {7'h00, c[0] & c[1] & usb_valid & !ac_valid}, {7'h00, charge_from_usb});
    chk("force", {7'h00, !c[7] & (ac_valid | usb_valid) & supply_above_lockout},
        {7'h00, force_on_mode});
    chk("wait", {7'h00, c[7] | !((ac_valid | usb_valid) & supply_above_lockout)},
        {7'h00, wait_mode_enable});
    chk("sda_out", 8'h00, {7'h00, sda_out});
    m.rd(dev, 8'h01, rd);
    chk("taper", {7'h00, c[5] ? taper_timer_done : taper_comparator}, {7'h00, rd[3]});
    rd_chk(8'h07, c);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    dev = {pmic_event_pkg::BUS_ADDR_HIGH, 1'b0};
    chk("quarters", 8'h04, {5'h00, charge_current_quarters});
    chk("int_n", 8'h01, {7'h00, int_n});
    rd_chk(8'h03, 8'hff);
    rd_chk(8'h04, 8'hff);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h07, 8'h1b);
    rd_chk(8'h00, 8'hff);
    rd_chk(8'h08, 8'hff);
    $display("test reset values done");
    bus_address_low_strap <= 1'b1;
    m.wr(dev, 8'h03, 8'h00, ok);
    chk("wrong address ack", 8'h00, {7'h00, ok});
    dev = {pmic_event_pkg::BUS_ADDR_HIGH, 1'b1};
    rd_chk(8'h03, 8'hff);
    m.wr(dev, 8'h05, 8'hff, ok);
    rd_chk(8'h05, 8'h00);
    $display("test addressing done");
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      rnd(s);
      s[4:3] = i[1:0];
      s[6] = 1'b0;
      @(posedge ref_clk);
      {ac_valid, usb_valid, supply_above_lockout, taper_comparator, taper_timer_done} <= v[4:0];
      wr(8'h07, s | 8'h40);
      wr(8'h07, s);
      chk("restarts", 8'(i + 1), restarts[7:0]);
      chk_setup(s);
    end
    $display("test charger setup done");
    for (int i = 0; i < 6; i++) begin
      rnd(v);
      rnd(s);
      @(posedge ref_clk);
      {ldo1_out_of_reg, ldo1_enabled, main_out_of_reg, core_out_of_reg, low_power_mode,
       core_off_in_low_power} <= v[5:0];
      rail_status_upper <= s[4:0];
      m.rd(dev, 8'h02, rd);
      chk("rail status", exp_rail(), rd);
    end
    {ldo1_out_of_reg, main_out_of_reg, core_out_of_reg, low_power_mode} <= 4'h0;
    rail_status_upper <= 5'h00;
    $display("test rail status done");
    repeat (4) @(posedge ref_clk);
    main_out_of_reg <= 1'b1;
    charge_status_reg <= 8'h80;
    repeat (4) @(posedge ref_clk);
    chk("int_n masked", 8'h01, {7'h00, int_n});
    main_out_of_reg <= 1'b0;
    charge_status_reg <= 8'h00;
    wr(8'h04, 8'hfd);
    wr(8'h03, 8'h7f);
    main_out_of_reg <= 1'b1;
    wait_int(1'b0);
    charge_status_reg <= 8'h80;
    pulse_ack(8'h80, 8'h00);
    chk("int_n one left", 8'h00, {7'h00, int_n});
    pulse_ack(8'h00, 8'h02);
    wait_int(1'b1);
    rd_chk(8'h05, 8'h80);
    rd_chk(8'h06, 8'h02);
    main_out_of_reg <= 1'b0;
    charge_status_reg <= 8'h00;
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h06, 8'h00);
    // clock enable low freezes event capture
    clk_en <= 1'b0;
    main_out_of_reg <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("int_n frozen", 8'h01, {7'h00, int_n});
    clk_en <= 1'b1;
    wait_int(1'b0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule

// ===== verif/pmic_event_properties.sv
`timescale 1ns/10ps
// port-level checks of the event and charger block
module pmic_event_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // watched ports
  input wire logic       scl_in,
  input wire logic       sda_oe,
  input wire logic       ac_valid,
  input wire logic       usb_valid,
  input wire logic       supply_above_lockout,
  input wire logic       int_n,
  input wire logic       force_on_mode,
  input wire logic       wait_mode_enable,
  input wire logic       charger_restart,
  input wire logic [2:0] charge_current_quarters,
  input wire logic       charge_from_ac,
  input wire logic       charge_from_usb
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);
  AST_WAIT_INV: assert property (wait_mode_enable == !force_on_mode)
    else $error("wait enable not inverse of force on");
  AST_FORCE_SRC: assert property (force_on_mode |->
    $past(ac_valid || usb_valid) && $past(supply_above_lockout))
    else $error("force on without valid source");
  AST_RESTART_ONE: assert property (charger_restart |=> !charger_restart)
    else $error("charger restart longer than one cycle");
  AST_USB_SRC: assert property (charge_from_usb |-> $past(usb_valid) && !$past(ac_valid))
    else $error("usb charging without usb or with ac");
  AST_AC_SRC: assert property (charge_from_ac |-> $past(ac_valid) && !charge_from_usb)
    else $error("ac charging without ac source");
  AST_QUARTERS: assert property (charge_current_quarters inside {3'h1, 3'h2, 3'h3, 3'h4})
    else $error("charge current code out of range");
  AST_SDA_STABLE: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data pull changed while clock high");
  AST_OE_ON_LOW: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data pull started while clock high");
  // main scenarios reached
  cover property ($fell(int_n));
  cover property (charger_restart);
  cover property (force_on_mode && charge_from_ac);
endmodule
bind pmic_event_and_charger_control pmic_event_properties u_props (
  .ref_clk, .arst_n, .scl_in, .sda_oe, .ac_valid, .usb_valid, .supply_above_lockout,
  .int_n, .force_on_mode, .wait_mode_enable, .charger_restart, .charge_current_quarters,
  .charge_from_ac, .charge_from_usb
);

// ===== verif/serial_master.sv
`timescale 1ns/10ps
// host-side two-wire master, one quarter bit is q clocks
module serial_master #(
  parameter int Q = 8
) (
  // clock
  input  wire logic ref_clk,
  // bus lines
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic sda_m;
  // pulled-up data wire, device pulls low
  assign sda_in = sda_m & !sda_oe;
  // idle bus at time zero
  initial begin
    scl_in = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one bit, data set while clock low, sampled mid-high
  task automatic put(input logic b, output logic got);
    sda_m <= b;
    tick(Q);
    scl_in <= 1'b1;
    tick(Q);
    got = sda_in;
    tick(Q);
    scl_in <= 1'b0;
    tick(Q);
  endtask
  // start or repeated start
  task automatic start();
    sda_m <= 1'b1;
    tick(Q);
    scl_in <= 1'b1;
    tick(Q);
    sda_m <= 1'b0;
    tick(Q);
    scl_in <= 1'b0;
    tick(Q);
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    tick(Q);
    scl_in <= 1'b1;
    tick(Q);
    sda_m <= 1'b1;
    tick(Q);
  endtask
  // byte msb first plus ninth bit; last high releases the line
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(tx[i], rx[i]);
    put(last, b);
    ack = !b;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                    output logic ok);
    logic [7:0] r;
    logic       k1, k2, k3;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k1);
    xfer(a, 1'b1, r, k2);
    xfer(d, 1'b1, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // set pointer, repeated start, one byte read then nack
  task automatic rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    logic       k;
    start();
    xfer({dev, 1'b0}, 1'b1, r, k);
    xfer(a, 1'b1, r, k);
    start();
    xfer({dev, 1'b1}, 1'b1, r, k);
    xfer(8'hff, 1'b1, d, k);
    stop();
  endtask
endmodule
